/* File: dis_pkg.sv */
// Constants, carrier types and state encoding of the dual inrush sequencer
package dis_pkg;

  localparam int unsigned NUM_CH       = 2;
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned CLK_KHZ      = CLK_HZ / 1_000;
  localparam int unsigned CLK_MHZ      = CLK_HZ / 1_000_000;

  // Times as printed, and their cycle counts at the clock rate
  localparam int unsigned DEBOUNCE_MS  = 100;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
  localparam int unsigned STARTUP_MS   = 100;
  localparam int unsigned STARTUP_CYC  = STARTUP_MS * CLK_KHZ;
  localparam int unsigned RETRY_S      = 5;
  localparam int unsigned RETRY_CYC    = RETRY_S * CLK_HZ;
  localparam int unsigned CB_US        = 20;
  localparam int unsigned CB_CYC       = CB_US * CLK_MHZ;
  localparam logic [12:0] CB_CYC_W     = 13'(CB_CYC);
  localparam int unsigned RETRY_RATIO  = 50;

  // Register bus widths
  localparam int unsigned ADDR_W       = 4;
  localparam int unsigned DATA_W       = 8;

  // Register offsets
  localparam logic [3:0] REG_CTRL0     = 4'h0;
  localparam logic [3:0] REG_CTRL1     = 4'h1;
  localparam logic [3:0] REG_ALERT0    = 4'h2;
  localparam logic [3:0] REG_ALERT1    = 4'h3;
  localparam logic [3:0] REG_FAULT0    = 4'h4;
  localparam logic [3:0] REG_FAULT1    = 4'h5;
  localparam logic [3:0] REG_STAT0     = 4'h6;
  localparam logic [3:0] REG_STAT1     = 4'h7;
  localparam logic [3:0] REG_BUSID     = 4'h8;

  // Control register fields
  localparam int unsigned CTL_RETRY    = 0;
  localparam int unsigned CTL_SWREQ    = 3;
  localparam int unsigned CTL_GPCFG    = 6;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [1:0]  GP_PGOOD     = 2'h0;
  localparam logic [1:0]  GP_PBAD      = 2'h1;
  localparam logic [1:0]  GP_LOW       = 2'h2;

  // Fault log fields
  localparam int unsigned F_OV         = 0;
  localparam int unsigned F_UV         = 1;
  localparam int unsigned F_OC         = 2;
  localparam int unsigned F_CB         = 3;
  localparam int unsigned F_PBAD       = 4;
  localparam int unsigned F_BP         = 5;
  localparam int unsigned FAULT_W      = 6;
  localparam logic [5:0]  FAULT_RST    = 6'h00;
  localparam logic [5:0]  ALERT_RST    = 6'h00;

  // Bus id: arbitrary neutral base value
  localparam logic [6:0]  BUS_ID_BASE  = 7'h20;

  typedef struct packed {
    logic board_present_n;
    logic switch_request;
    logic high_limit;
    logic low_limit;
    logic low_reset;
    logic fb_low;
    logic cb_over;
    logic limiting;
    logic gp_in;
  } dis_chan_pins_t;

  typedef struct packed {
    logic       pairing;
    logic       timer_on_rail;
    logic       timer_cap_done;
    logic       supply_uvlo;
    logic [2:0] id_high;
    logic [2:0] id_low;
  } dis_glob_pins_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dis_bus_req_t;

  localparam dis_chan_pins_t CHAN_PINS_RST = 9'h100;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_STARTUP,
    ST_RUN,
    ST_COOL
  } dis_state_t;

endpackage : dis_pkg

/* File: dis_sequencer.sv */
// Dual channel inrush sequencer: start-up, fault log, power good and alert logic
//
// Summary of operation
// [R1] Enabled logged fault pulls alert low
// [R2] Pairing low: start together, stop together
// [R3] Pairing high: each channel runs alone
// [R4] Independent start waits for other start-up
// [R5] Board-present high keeps pass drive off
// [R6] Every board-present edge logged as fault
// [R7] Board-present fall samples request, clears faults
// [R8] Divider low means power bad; pin configurable
// [R9] Power-bad logged when low, running, driven
// [R10] Foldback only in start-up, then fixed
// [R11] Gentle pull-down normally, strong on short
// [R12] Good pin resets to pull-low-when-bad
// [R13] Request rise turns on, fall turns off
// [R14] Request bit follows pin after debounce
// [R15] Request fall clears channel fault log
// [R16] Over limit logs fault, drive off
// [R17] Breaker trips after 20us over 50mV
// [R18] Start-up timeout while limiting logs overcurrent
// [R19] Rail-tied timer: 100ms start, 5s retry
// [R20] Under limit logs fault, drive off
// [R21] Deep undervoltage clears log except undervoltage
// [R22] Three three-level selects give 27 addresses
// [R23] Conditions hold 100ms before turn-on
// [R24] Paired start needs both pins or bits
// [R25] All pins synchronised before use
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module dis_sequencer #(
  parameter int unsigned DEBOUNCE_CYC = dis_pkg::DEBOUNCE_CYC,
  parameter int unsigned STARTUP_CYC  = dis_pkg::STARTUP_CYC,
  parameter int unsigned RETRY_CYC    = dis_pkg::RETRY_CYC
) (
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  input  wire dis_pkg::dis_bus_req_t      bus_req_in,
  output logic [7:0]                      rd_data_out,
  input  wire dis_pkg::dis_chan_pins_t [1:0] chan_pins_in,
  input  wire dis_pkg::dis_glob_pins_t    glob_pins_in,
  output logic [1:0]                      pass_drive_out,
  output logic [1:0]                      foldback_en_out,
  output logic [1:0]                      gentle_pd_out,
  output logic [1:0]                      strong_pd_out,
  output logic [1:0]                      good_flag_out,
  output logic [1:0]                      good_flag_oe_out,
  output logic                            alert_out,
  output logic                            alert_oe_out,
  output logic [6:0]                      bus_addr_out
);
  import dis_pkg::*;

  dis_chan_pins_t [1:0] ch_meta_r;
  dis_chan_pins_t [1:0] ch_s_r;
  dis_chan_pins_t [1:0] ch_prev_r;
  dis_glob_pins_t       gl_meta_r;
  dis_glob_pins_t       gl_s_r;

  logic [31:0]          deb_cnt_r   [2];
  logic [31:0]          tmr_r       [2];
  logic [31:0]          su_len_r    [2];
  logic [12:0]          cb_cnt_r    [2];
  dis_state_t           st_r        [2];
  logic [7:0]           ctrl_r      [2];
  logic [5:0]           alert_en_r  [2];
  logic [5:0]           fault_r     [2];

  logic [1:0]           pass_r;
  logic [1:0]           fold_r;
  logic [1:0]           gentle_r;
  logic [1:0]           strong_r;
  logic [1:0]           gf_oe_r;
  logic                 alert_oe_r;
  logic [6:0]           bus_addr_r;
  logic [7:0]           rd_data_r;

  logic [1:0]           bp_fall;
  logic [1:0]           bp_edge;
  logic [1:0]           sw_rise;
  logic [1:0]           sw_fall;
  logic [1:0]           cond_ok;
  logic [1:0]           qual;
  logic [1:0]           qual_rise;
  logic [1:0]           stop;
  logic [1:0]           kill;
  logic [1:0]           oc_trip;
  logic [1:0]           cb_trip;
  logic [1:0]           su_done;
  logic [1:0]           blocked;
  logic [1:0]           start_ok;
  logic [1:0]           go;
  logic [1:0]           pgood;
  logic [31:0]          cool_len    [2];
  logic                 paired;
  logic                 want_pair;

  // Register address decode shared by reads and writes
  function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
    hit = (a == idx);
  endfunction : hit

  // Three-level select: low gives 0, open gives 1, high gives 2
  function automatic logic [6:0] trit(input logic hi, input logic lo);
    if (lo) begin
      trit = 7'h00;
    end else if (hi) begin
      trit = 7'h02;
    end else begin
      trit = 7'h01;
    end
  endfunction : trit

  // [R25] Two-stage input synchroniser
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ch_meta_r <= {CHAN_PINS_RST, CHAN_PINS_RST};
      ch_s_r    <= {CHAN_PINS_RST, CHAN_PINS_RST};
      ch_prev_r <= {CHAN_PINS_RST, CHAN_PINS_RST};
      gl_meta_r <= '0;
      gl_s_r    <= '0;
    end else begin
      ch_meta_r <= chan_pins_in;
      ch_s_r    <= ch_meta_r;
      ch_prev_r <= ch_s_r;
      gl_meta_r <= glob_pins_in;
      gl_s_r    <= gl_meta_r;
    end
  end

  always_comb begin
    paired    = !gl_s_r.pairing;
    // [R24] Paired start needs both pins or both bits
    want_pair = (ch_s_r[0].switch_request & ch_s_r[1].switch_request) |
                (ctrl_r[0][CTL_SWREQ] & ctrl_r[1][CTL_SWREQ]);
    for (int c = 0; c < NUM_CH; c++) begin
      bp_fall[c]   = ch_prev_r[c].board_present_n & !ch_s_r[c].board_present_n;
      bp_edge[c]   = ch_prev_r[c].board_present_n ^ ch_s_r[c].board_present_n;
      sw_rise[c]   = !ch_prev_r[c].switch_request & ch_s_r[c].switch_request;
      sw_fall[c]   = ch_prev_r[c].switch_request & !ch_s_r[c].switch_request;
      // [R5] Board-present high forbids turn-on
      cond_ok[c]   = !ch_s_r[c].board_present_n & !ch_s_r[c].high_limit &
                     !ch_s_r[c].low_limit;
      qual[c]      = cond_ok[c] && (deb_cnt_r[c] == DEBOUNCE_CYC);
      qual_rise[c] = cond_ok[c] && (deb_cnt_r[c] == DEBOUNCE_CYC - 1);
      // [R19] Internal period when timer pin tied to rail
      su_done[c]   = gl_s_r.timer_on_rail ? (tmr_r[c] >= STARTUP_CYC - 1)
                                          : gl_s_r.timer_cap_done;
      cool_len[c]  = gl_s_r.timer_on_rail ? RETRY_CYC
                                          : 32'(su_len_r[c] * RETRY_RATIO);
      // [R18] Start-up expiry while still limiting
      oc_trip[c]   = (st_r[c] == ST_STARTUP) && su_done[c] && ch_s_r[c].limiting;
      // [R17] Breaker after continuous over-threshold time
      cb_trip[c]   = (st_r[c] == ST_RUN) && ch_s_r[c].cb_over &&
                     (cb_cnt_r[c] == CB_CYC_W - 13'h0001);
      // [R16] [R20] Limit comparators force the drive off
      stop[c]      = ch_s_r[c].board_present_n | ch_s_r[c].high_limit |
                     ch_s_r[c].low_limit | gl_s_r.supply_uvlo |
                     !(paired ? want_pair : ctrl_r[c][CTL_SWREQ]);
      // Latched overcurrent or breaker fault blocks restart unless retry is on
      blocked[c]   = (fault_r[c][F_OC] | fault_r[c][F_CB]) & !ctrl_r[c][CTL_RETRY];
      pgood[c]     = !ch_s_r[c].fb_low;
    end
    // [R2] Paired: any stop or trip stops both
    if (paired) begin
      kill     = {2{|stop | |oc_trip | |cb_trip}};
      start_ok = {2{&qual & want_pair & !(|blocked) &
                    (st_r[0] == ST_OFF) & (st_r[1] == ST_OFF)}};
      go       = start_ok;
    end else begin
      // [R3] Independent: each channel's stop and start terms see only itself
      kill = stop;
      for (int c = 0; c < NUM_CH; c++) begin
        start_ok[c] = qual[c] & ctrl_r[c][CTL_SWREQ] & !blocked[c] & (st_r[c] == ST_OFF);
      end
      // [R4] Defer while the other channel starts up
      go[0] = start_ok[0] & (st_r[1] != ST_STARTUP);
      go[1] = start_ok[1] & (st_r[0] != ST_STARTUP) & !go[0];
    end
  end

  // [R23] Insertion debounce
  always_ff @(posedge clk_in) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (!rst_n_in || !cond_ok[c]) begin
        deb_cnt_r[c] <= 32'h00000000;
      end else if (deb_cnt_r[c] < DEBOUNCE_CYC) begin
        deb_cnt_r[c] <= deb_cnt_r[c] + 32'h00000001;
      end
    end
  end

  // Channel sequencing
  always_ff @(posedge clk_in) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (!rst_n_in) begin
        st_r[c]     <= ST_OFF;
        tmr_r[c]    <= 32'h00000000;
        su_len_r[c] <= 32'h00000001;
      end else begin
        case (st_r[c])
          ST_OFF: begin
            tmr_r[c] <= 32'h00000000;
            if (go[c]) begin
              st_r[c] <= ST_STARTUP;
            end
          end
          ST_STARTUP: begin
            tmr_r[c] <= tmr_r[c] + 32'h00000001;
            if (oc_trip[c]) begin
              st_r[c]  <= ST_COOL;
              tmr_r[c] <= 32'h00000000;
            end else if (kill[c]) begin
              st_r[c] <= ST_OFF;
            end else if (su_done[c]) begin
              st_r[c]     <= ST_RUN;
              su_len_r[c] <= tmr_r[c] + 32'h00000001;
            end
          end
          ST_RUN: begin
            tmr_r[c] <= 32'h00000000;
            if (cb_trip[c]) begin
              st_r[c] <= ST_COOL;
            end else if (kill[c]) begin
              st_r[c] <= ST_OFF;
            end
          end
          ST_COOL: begin
            // Cool-down before another attempt is allowed
            tmr_r[c] <= tmr_r[c] + 32'h00000001;
            if (tmr_r[c] >= cool_len[c] - 32'h00000001) begin
              st_r[c] <= ST_OFF;
            end
          end
          default: begin
            st_r[c] <= ST_OFF;
          end
        endcase
      end
    end
  end

  // [R17] Breaker over-threshold timer
  always_ff @(posedge clk_in) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (!rst_n_in || st_r[c] != ST_RUN || !ch_s_r[c].cb_over) begin
        cb_cnt_r[c] <= 13'h0000;
      end else if (cb_cnt_r[c] != CB_CYC_W) begin
        cb_cnt_r[c] <= cb_cnt_r[c] + 13'h0001;
      end
    end
  end

  // Control registers and switch request bit
  always_ff @(posedge clk_in) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (!rst_n_in) begin
        // [R12] Good pin defaults to pull-low-when-bad
        ctrl_r[c] <= CTRL_RST;
      end else begin
        if (bus_req_in.wr && hit(bus_req_in.addr, REG_CTRL0 + 4'(c))) begin
          ctrl_r[c] <= bus_req_in.wdata;
        end
        // Pin events override a software write in the same cycle
        // [R14] Bit follows pin once qualified
        if (qual_rise[c]) begin
          ctrl_r[c][CTL_SWREQ] <= ch_s_r[c].switch_request;
        end
        // [R7] Sample request on insertion
        if (bp_fall[c]) begin
          ctrl_r[c][CTL_SWREQ] <= ch_s_r[c].switch_request;
        end
        // [R13] Request edges switch the channel
        if (sw_rise[c]) begin
          ctrl_r[c][CTL_SWREQ] <= 1'b1;
        end else if (sw_fall[c]) begin
          ctrl_r[c][CTL_SWREQ] <= 1'b0;
        end
      end
    end
  end

  // Alert enables
  always_ff @(posedge clk_in) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (!rst_n_in) begin
        alert_en_r[c] <= ALERT_RST;
      end else if (bus_req_in.wr && hit(bus_req_in.addr, REG_ALERT0 + 4'(c))) begin
        alert_en_r[c] <= bus_req_in.wdata[FAULT_W-1:0];
      end
    end
  end

  // Fault log: clears first, sets last so a fresh event wins
  always_ff @(posedge clk_in) begin
    logic [5:0] f;
    for (int c = 0; c < NUM_CH; c++) begin
      f = fault_r[c];
      if (bus_req_in.wr && hit(bus_req_in.addr, REG_FAULT0 + 4'(c))) begin
        f = f & ~bus_req_in.wdata[FAULT_W-1:0];
      end
      // [R15] [R7] Request fall or insertion clears log
      if (sw_fall[c] || bp_fall[c]) begin
        f = FAULT_RST;
      end
      // [R21] Deep undervoltage keeps only undervoltage
      if (ch_s_r[c].low_reset) begin
        f = f & (6'h01 << F_UV);
      end
      // [R16] Overvoltage fault
      f[F_OV] = f[F_OV] | ch_s_r[c].high_limit;
      // [R20] Undervoltage fault
      f[F_UV] = f[F_UV] | ch_s_r[c].low_limit;
      // [R18] Overcurrent at start-up end
      f[F_OC] = f[F_OC] | oc_trip[c];
      f[F_CB] = f[F_CB] | cb_trip[c];
      // [R9] Power bad only when running and driven
      f[F_PBAD] = f[F_PBAD] | (ch_s_r[c].fb_low & (st_r[c] == ST_RUN) & pass_r[c]);
      // [R6] Every board-present transition logged
      f[F_BP] = f[F_BP] | bp_edge[c];
      if (!rst_n_in) begin
        fault_r[c] <= FAULT_RST;
      end else begin
        fault_r[c] <= f;
      end
    end
  end

  // Gate drive and current-limit selection
  always_ff @(posedge clk_in) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (!rst_n_in) begin
        pass_r[c]   <= 1'b0;
        fold_r[c]   <= 1'b0;
        gentle_r[c] <= 1'b1;
        strong_r[c] <= 1'b0;
      end else begin
        pass_r[c]   <= ((st_r[c] == ST_STARTUP) || (st_r[c] == ST_RUN)) && !gl_s_r.supply_uvlo;
        // [R10] Foldback only during start-up
        fold_r[c]   <= (st_r[c] == ST_STARTUP) && !gl_s_r.supply_uvlo;
        // [R11] Strong pull-down on short or lockout
        strong_r[c] <= gl_s_r.supply_uvlo ||
                       ((st_r[c] == ST_COOL) && fault_r[c][F_CB]);
        gentle_r[c] <= !((st_r[c] == ST_STARTUP) || (st_r[c] == ST_RUN)) &&
                       !(gl_s_r.supply_uvlo ||
                         ((st_r[c] == ST_COOL) && fault_r[c][F_CB]));
      end
    end
  end

  // [R8] Good pin mode from control bits 7:6
  always_ff @(posedge clk_in) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (!rst_n_in) begin
        gf_oe_r[c] <= 1'b1;
      end else begin
        case (ctrl_r[c][CTL_GPCFG +: 2])
          GP_PGOOD: gf_oe_r[c] <= !pgood[c];
          GP_PBAD:  gf_oe_r[c] <= pgood[c];
          GP_LOW:   gf_oe_r[c] <= 1'b1;
          default:  gf_oe_r[c] <= 1'b0;
        endcase
      end
    end
  end

  // [R1] Alert follows enabled logged faults
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      alert_oe_r <= 1'b0;
    end else begin
      alert_oe_r <= |((fault_r[0] & alert_en_r[0]) | (fault_r[1] & alert_en_r[1]));
    end
  end

  // [R22] Bus id decode, 27 combinations
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bus_addr_r <= BUS_ID_BASE;
    end else begin
      bus_addr_r <= BUS_ID_BASE + trit(gl_s_r.id_high[0], gl_s_r.id_low[0]) +
                    7'(3 * trit(gl_s_r.id_high[1], gl_s_r.id_low[1])) +
                    7'(9 * trit(gl_s_r.id_high[2], gl_s_r.id_low[2]));
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !bus_req_in.rd) begin
      rd_data_r <= 8'h00;
    end else if (hit(bus_req_in.addr, REG_CTRL0)) begin
      rd_data_r <= ctrl_r[0];
    end else if (hit(bus_req_in.addr, REG_CTRL1)) begin
      rd_data_r <= ctrl_r[1];
    end else if (hit(bus_req_in.addr, REG_ALERT0)) begin
      rd_data_r <= {2'h0, alert_en_r[0]};
    end else if (hit(bus_req_in.addr, REG_ALERT1)) begin
      rd_data_r <= {2'h0, alert_en_r[1]};
    end else if (hit(bus_req_in.addr, REG_FAULT0)) begin
      rd_data_r <= {2'h0, fault_r[0]};
    end else if (hit(bus_req_in.addr, REG_FAULT1)) begin
      rd_data_r <= {2'h0, fault_r[1]};
    end else if (hit(bus_req_in.addr, REG_STAT0)) begin
      rd_data_r <= {gl_s_r.pairing, pass_r[0], qual[0], ch_s_r[0].gp_in, pgood[0],
                    ch_s_r[0].board_present_n, ch_s_r[0].low_limit, ch_s_r[0].high_limit};
    end else if (hit(bus_req_in.addr, REG_STAT1)) begin
      rd_data_r <= {gl_s_r.pairing, pass_r[1], qual[1], ch_s_r[1].gp_in, pgood[1],
                    ch_s_r[1].board_present_n, ch_s_r[1].low_limit, ch_s_r[1].high_limit};
    end else if (hit(bus_req_in.addr, REG_BUSID)) begin
      rd_data_r <= {1'b0, bus_addr_r};
    end else begin
      rd_data_r <= 8'h00;
    end
  end

  assign rd_data_out      = rd_data_r;
  assign pass_drive_out   = pass_r;
  assign foldback_en_out  = fold_r;
  assign gentle_pd_out    = gentle_r;
  assign strong_pd_out    = strong_r;
  assign good_flag_oe_out = gf_oe_r;
  assign alert_oe_out     = alert_oe_r;
  assign bus_addr_out     = bus_addr_r;
  // Open-drain pins only ever drive low
  assign good_flag_out    = 2'b00;
  assign alert_out        = 1'b0;

endmodule : dis_sequencer
`default_nettype wire

/* File: dis_seq_props.sv */
// Port checker of the dual inrush sequencer, bound to the design
`timescale 1ns/1ps
`default_nettype none
module dis_seq_props
  import dis_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYC = 20
) (
  input wire logic                          clk_in,
  input wire logic                          rst_n_in,
  input wire dis_pkg::dis_chan_pins_t [1:0] chan_pins_in,
  input wire dis_pkg::dis_glob_pins_t       glob_pins_in,
  input wire logic [1:0]                    pass_drive_out,
  input wire logic [1:0]                    foldback_en_out,
  input wire logic [1:0]                    gentle_pd_out,
  input wire logic [1:0]                    strong_pd_out,
  input wire logic [1:0]                    good_flag_out,
  input wire logic                          alert_out
);
  default clocking dc @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  for (genvar i = 0; i < 2; i++) begin : g_ch
    int qual_r;
    int over_r;
    // Raw pin counts run ahead of the synchronised ones, so bounds stay safe
    always_ff @(posedge clk_in) begin
      qual_r <= (!rst_n_in || chan_pins_in[i].board_present_n || chan_pins_in[i].high_limit
                 || chan_pins_in[i].low_limit) ? 0 : qual_r + 1;
      over_r <= (!rst_n_in || !chan_pins_in[i].cb_over) ? 0 : over_r + 1;
    end
    a_debounce_held: assert property ($rose(pass_drive_out[i]) |-> qual_r >= int'(DEBOUNCE_CYC))
      else $error("pass drive rose before conditions held");
    a_absent_off: assert property (chan_pins_in[i].board_present_n [*6] |-> !pass_drive_out[i])
      else $error("pass drive on with board absent");
    a_request_off: assert property ($fell(chan_pins_in[i].switch_request) |-> ##[1:8] !pass_drive_out[i])
      else $error("pass drive stayed on after request fell");
    a_fold_start: assert property (foldback_en_out[i] |-> pass_drive_out[i])
      else $error("foldback active without start-up drive");
    a_pd_idle: assert property (pass_drive_out[i] |-> !(gentle_pd_out[i] || strong_pd_out[i]))
      else $error("gate pull-down active while driving");
    a_breaker_time: assert property ($rose(strong_pd_out[i]) |->
      (over_r >= int'(CB_CYC)) || glob_pins_in.supply_uvlo)
      else $error("strong pull-down without a long over-current");
  end
  a_paired_same: assert property (!glob_pins_in.pairing [*6] |-> pass_drive_out[0] == pass_drive_out[1])
    else $error("paired channels differ");
  a_open_drain: assert property (good_flag_out == 2'b00 && !alert_out)
    else $error("open-drain data not low");
  cover property ($rose(pass_drive_out[0]));
  cover property ($rose(strong_pd_out[0]));
  cover property (pass_drive_out == 2'b01);
endmodule : dis_seq_props

bind dis_sequencer dis_seq_props #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) props_u (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .chan_pins_in(chan_pins_in),
  .glob_pins_in(glob_pins_in), .pass_drive_out(pass_drive_out),
  .foldback_en_out(foldback_en_out), .gentle_pd_out(gentle_pd_out),
  .strong_pd_out(strong_pd_out), .good_flag_out(good_flag_out), .alert_out(alert_out));
`default_nettype wire

/* File: dis_far_model.sv */
// Far side model: pass transistors, load ramp, shunt and good pin pull-up
`timescale 1ns/1ps
`default_nettype none
module dis_far_model (
  input  wire logic       clk_in,
  input  wire logic [1:0] pass_in,
  input  wire logic [1:0] good_oe_in,
  input  wire logic [1:0] short_in,
  output wire logic [1:0] limiting_out,
  output wire logic [1:0] fb_low_out,
  output wire logic [1:0] cb_over_out,
  output wire logic [1:0] gp_out
);
  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [3:0] ramp_r;
    // Load charges for 8 cycles; a short holds the loop in current limit
    always_ff @(posedge clk_in) begin
      ramp_r <= !pass_in[i] ? 4'h0 : (ramp_r == 4'h8) ? 4'h8 : ramp_r + 4'h1;
    end
    assign limiting_out[i] = pass_in[i] && (ramp_r != 4'h8 || short_in[i]);
    assign fb_low_out[i]   = !(pass_in[i] && ramp_r == 4'h8);
    assign cb_over_out[i]  = pass_in[i] && short_in[i];
    // Pull-up wins once the pin is released
    assign gp_out[i]       = !good_oe_in[i];
  end
endmodule : dis_far_model
`default_nettype wire

/* File: test_dual_channel_inrush_sequencer.sv */
// Self-checking bench of the dual inrush sequencer and its far side
`timescale 1ns/1ps
`default_nettype none
module test_dual_channel_inrush_sequencer;
  import dis_pkg::*;
  logic                 clk_in;
  logic                 rst_n_in = 1'b0;
  dis_bus_req_t         bus_req  = '0;
  dis_glob_pins_t       glob     = 10'h100;
  wire dis_chan_pins_t [1:0] pins;
  logic [7:0]           rd_data;
  logic [6:0]           bus_addr;
  logic [1:0]           pass, fold, gpd, spd, goe, lim, fbl, cbo, gpi;
  logic [1:0]           bp_n = 2'b11, req = 2'b00, hi = 2'b00, lo = 2'b00, lrst = 2'b00;
  logic [1:0]           shrt = 2'b00;
  logic                 alert_oe;
  logic [31:0]          seed = 32'h0E83;
  int                   err_total = 0;
  int                   n_checks = 0;
  int                   cyc = 0;
  for (genvar i = 0; i < 2; i++) begin : g_pin
    assign pins[i] = {bp_n[i], req[i], hi[i], lo[i], lrst[i], fbl[i], cbo[i], lim[i], gpi[i]};
  end
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Short counts keep the run brief; expectations follow these values
  dis_sequencer #(.DEBOUNCE_CYC(20), .STARTUP_CYC(30), .RETRY_CYC(50)) dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .bus_req_in(bus_req), .rd_data_out(rd_data),
    .chan_pins_in(pins), .glob_pins_in(glob), .pass_drive_out(pass), .foldback_en_out(fold),
    .gentle_pd_out(gpd), .strong_pd_out(spd), .good_flag_out(), .good_flag_oe_out(goe),
    .alert_out(), .alert_oe_out(alert_oe), .bus_addr_out(bus_addr));
  dis_far_model far_u (.clk_in(clk_in), .pass_in(pass), .good_oe_in(goe),
    .short_in(shrt), .limiting_out(lim), .fb_low_out(fbl), .cb_over_out(cbo), .gp_out(gpi));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [7:0] exp_addr(input logic [31:0] r);
    return {1'b0, BUS_ID_BASE} + 8'(r[1:0] % 3) + 8'h03 * 8'(r[3:2] % 3) + 8'h09 * 8'(r[5:4] % 3);
  endfunction : exp_addr
  function automatic logic [7:0] probe(input int w);
    case (w)
      0: return {6'h00, pass};
      1: return {6'h00, spd};
      2: return {6'h00, goe};
      3: return {7'h00, alert_oe};
      default: return {6'h00, fold};
    endcase
  endfunction : probe
  task automatic close_out();
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus_req <= '{a, d, w, !w};
    @(posedge clk_in);
    bus_req <= '0;
  endtask : bus
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    #1 chk(rd_data, e);
  endtask : rd_chk
  task automatic wait_val(input int w, input logic [7:0] e, input int lim);
    for (int k = 0; k < lim && probe(w) !== e; k++) begin
      @(posedge clk_in);
      #1;
    end
    chk(probe(w), e);
  endtask : wait_val
  // Hang guard, well above the expected run length
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    logic [2:0] idh, idl;
    int         v;
    repeat (11) @(posedge clk_in);
    #1 chk({gpd, goe, pass}, 8'h3C);
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    bp_n <= 2'b00;
    req <= 2'b11;
    for (int n = 0; n < 6; n++) begin
      seed = xs(seed);
      for (int k = 0; k < 3; k++) begin
        v = int'(seed[2*k +: 2]) % 3;
        idl[k] = (v == 0);
        idh[k] = (v == 2);
      end
      glob <= {glob[9:6], idh, idl};
      repeat (5) @(posedge clk_in);
      #1 chk({1'b0, bus_addr}, exp_addr(seed));
      @(posedge clk_in);
    end
    wait_val(0, 8'h03, 200);
    rd_chk(REG_CTRL0, 8'h08);
    rd_chk(REG_FAULT0, 8'h20);
    bus(1'b1, REG_ALERT0, seed[15:8]);
    rd_chk(REG_ALERT0, seed[15:8] & 8'h3F);
    rd_chk(4'hF, 8'h00);
    bus(1'b1, REG_ALERT0, 8'h00);
    wait_val(4, 8'h00, 60);
    wait_val(2, 8'h00, 40);
    @(posedge clk_in);
    req <= 2'b10;
    wait_val(0, 8'h00, 20);
    wait_val(2, 8'h03, 20);
    chk({6'h00, gpd}, 8'h03);
    rd_chk(REG_FAULT0, 8'h00);
    @(posedge clk_in);
    glob.pairing <= 1'b1;
    req <= 2'b01;
    wait_val(0, 8'h01, 20);
    @(posedge clk_in);
    req <= 2'b11;
    repeat (8) @(posedge clk_in);
    #1 chk({6'h00, pass}, 8'h01);
    wait_val(0, 8'h03, 60);
    @(posedge clk_in);
    hi <= 2'b10;
    wait_val(0, 8'h01, 20);
    bus(1'b1, REG_ALERT1, 8'h01);
    wait_val(3, 8'h01, 10);
    rd_chk(REG_FAULT1, 8'h01);
    @(posedge clk_in);
    hi <= 2'b00;
    repeat (6) @(posedge clk_in);
    bus(1'b1, REG_FAULT1, 8'h01);
    wait_val(3, 8'h00, 10);
    @(posedge clk_in);
    shrt <= 2'b01;
    repeat (3900) @(posedge clk_in);
    #1 chk({6'h00, spd}, 8'h00);
    wait_val(1, 8'h01, 300);
    rd_chk(REG_FAULT0, 8'h08);
    @(posedge clk_in);
    shrt <= 2'b00;
    bp_n <= 2'b10;
    wait_val(0, 8'h00, 20);
    rd_chk(REG_FAULT1, 8'h20);
    @(posedge clk_in);
    lo <= 2'b10;
    lrst <= 2'b10;
    repeat (6) @(posedge clk_in);
    rd_chk(REG_FAULT1, 8'h02);
    close_out();
  end
endmodule : test_dual_channel_inrush_sequencer
`default_nettype wire
